// file: logic/adc_ctl_cfg.svh
// Purpose: Constants for the converter control block
// Assumes: 100 MHz system clock, AXI4-Lite register access
// Notes:   Offsets are byte addresses of 32-bit words
`ifndef ADC_CTL_CFG_SVH
`define ADC_CTL_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_CONTROL      4'h0
`define OFS_CHAN_CFG     4'h4
`define OFS_PRESCALE     4'h8
`define OFS_RESULT       4'hC

// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define CTL_SEL_LSB      0
`define CTL_START_BIT    3
`define CTL_EOC_BIT      4
`define CTL_EN_BIT       5
`define CTL_PREC_BIT     6
`define CTL_IEN_BIT      7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_CONTROL      8'h00
`define RST_CHAN_CFG     8'h00
`define RST_PRESCALE     5'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CONV_PERIODS     11
`define ZERO_PRS_DIV     64
`define CONV_TYP_US      16
`define CLK_MHZ          100
`define CONV_TYP_CYC     (`CONV_TYP_US * `CLK_MHZ)

`endif

// file: logic/adc_ctl_pkg.sv
// Purpose: Types for the converter control block
// Assumes: Nothing
// Notes:   Conversion sequencer states
package adc_ctl_pkg;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONV   = 2'b11,
    ST_DONE   = 2'b10
  } conv_state_e;

endpackage : adc_ctl_pkg

// file: logic/adc_clk_div.sv
// Purpose: Converter clock enable from the peripheral clock
// Assumes: Prescale value is static while converting
// Notes:   Zero prescale divides by 64, otherwise by 2*prs
`timescale 1ns/1ns
`include "adc_ctl_cfg.svh"
module adc_clk_div #(
  parameter int PRS_W = 5
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Control
  input  wire logic             run_i,
  input  wire logic [PRS_W-1:0] prs_i,
  // Enable pulse
  output logic                  tick_o
);

  logic [6:0] cnt_r;
  logic [6:0] limit;

  if (PRS_W < 1 || PRS_W > 5) begin : g_bad_prs
    $error("PRS_W out of range");
  end

  assign limit = (prs_i == '0) ? 7'(`ZERO_PRS_DIV - 1)
                               : 7'({prs_i, 1'b0} - 1);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !run_i) begin
      cnt_r  <= 7'h00;
      tick_o <= 1'b0;
    end else if (cnt_r >= limit) begin
      cnt_r  <= 7'h00;
      tick_o <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 7'h01;
      tick_o <= 1'b0;
    end
  end

endmodule : adc_clk_div

// file: logic/adc_conversion_control.sv
// Purpose: Converter control with AXI4-Lite registers
// Assumes: Analog core is modelled by a sampled result input
// Notes:   Core halt and interrupt deferral are ports to the core
`timescale 1ns/1ns
`include "adc_ctl_cfg.svh"

module adc_conversion_control #(
  parameter int NCH    = 8,
  parameter int RES_W  = 10,
  parameter int PRS_W  = 5
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // AXI4-Lite write address
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [3:0]        s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // AXI4-Lite write response
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [3:0]        s_axi_araddr,
  // AXI4-Lite read data
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  // Analog core
  output logic [2:0]             mux_sel_o,
  output logic                   sample_o,
  output logic                   conv_en_o,
  input  wire logic [RES_W-1:0]  conv_result_i,
  // Port 1 pin ownership
  output logic [NCH-1:0]         pin_analog_o,
  // Processor core
  output logic                   core_halt_o,
  output logic                   defer_irq_o,
  output logic                   eoc_irq_o
);

  localparam logic [1:0] RESP_OK  = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;

  adc_ctl_pkg::conv_state_e state_r;

  logic [2:0]       sel_r;
  logic             start_r;
  logic             eoc_r;
  logic             en_r;
  logic             prec_r;
  logic             ien_r;
  logic             prec_run_r;
  logic [NCH-1:0]   chcfg_r;
  logic [PRS_W-1:0] prs_r;
  logic [RES_W-1:0] result_r;
  logic [3:0]       bitcnt_r;
  logic             tick;
  logic             busy;
  logic             aw_held_r;
  logic             w_held_r;
  logic [3:0]       awaddr_r;
  logic [31:0]      wdata_r;
  logic [3:0]       wstrb_r;
  logic             wr_fire;
  logic             ctl_wr;
  logic             cfg_wr;
  logic             prs_wr;
  logic             start_req;
  logic             eoc_set;

  if (NCH != 8) begin : g_bad_nch
    $error("NCH must be 8");
  end
  if (RES_W != 10) begin : g_bad_res
    $error("RES_W must be 10");
  end

  // --------------------------------------------------------------
  // Register access helpers
  // --------------------------------------------------------------
  function automatic logic addr_ok(input logic [3:0] a);
    addr_ok = (a == `OFS_CONTROL) || (a == `OFS_CHAN_CFG) ||
              (a == `OFS_PRESCALE) || (a == `OFS_RESULT);
  endfunction : addr_ok

  function automatic logic [2:0] chan_of(input logic [31:0] w);
    chan_of = w[`CTL_SEL_LSB +: 3];
  endfunction : chan_of

  function automatic logic reg_hit(input logic fire, input logic [3:0] strb,
                                   input logic [3:0] a, input logic [3:0] ofs);
    reg_hit = fire && strb[0] && (a == ofs);
  endfunction : reg_hit

  // --------------------------------------------------------------
  // Converter clock enable
  // --------------------------------------------------------------
  adc_clk_div #(
    .PRS_W (PRS_W)
  ) u_div (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .run_i   (busy),
    .prs_i   (prs_r),
    .tick_o  (tick)
  );

  // --------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign wr_fire       = aw_held_r && w_held_r && !s_axi_bvalid;
  assign ctl_wr        = reg_hit(wr_fire, wstrb_r, awaddr_r, `OFS_CONTROL);
  assign cfg_wr        = reg_hit(wr_fire, wstrb_r, awaddr_r, `OFS_CHAN_CFG);
  assign prs_wr        = reg_hit(wr_fire, wstrb_r, awaddr_r, `OFS_PRESCALE);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      w_held_r <= 1'b0;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb_r  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OK;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_ok(awaddr_r) ? RESP_OK : RESP_ERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Software-written registers
  // --------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sel_r  <= 3'h0;
      en_r   <= 1'b0;
      prec_r <= 1'b0;
      ien_r  <= 1'b0;
    end else if (ctl_wr) begin
      sel_r  <= chan_of(wdata_r);
      en_r   <= wdata_r[`CTL_EN_BIT];
      prec_r <= wdata_r[`CTL_PREC_BIT];
      ien_r  <= wdata_r[`CTL_IEN_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      chcfg_r <= NCH'(`RST_CHAN_CFG);
    end else if (cfg_wr) begin
      chcfg_r <= wdata_r[NCH-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prs_r <= PRS_W'(`RST_PRESCALE);
    end else if (prs_wr) begin
      prs_r <= wdata_r[PRS_W-1:0];
    end
  end

  assign pin_analog_o = chcfg_r;

  // --------------------------------------------------------------
  // Conversion sequencer
  // --------------------------------------------------------------
  assign busy      = (state_r != adc_ctl_pkg::ST_IDLE);
  // Start only on an enabled, selected channel when idle
  assign start_req = ctl_wr && wdata_r[`CTL_START_BIT] && !busy
                     && chcfg_r[chan_of(wdata_r)];
  assign eoc_set   = (state_r == adc_ctl_pkg::ST_DONE);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_r    <= adc_ctl_pkg::ST_IDLE;
      bitcnt_r   <= 4'h0;
      prec_run_r <= 1'b0;
    end else begin
      case (state_r)
        adc_ctl_pkg::ST_IDLE: begin
          if (start_req) begin
            state_r    <= adc_ctl_pkg::ST_SAMPLE;
            prec_run_r <= wdata_r[`CTL_PREC_BIT];
          end
        end
        adc_ctl_pkg::ST_SAMPLE: begin
          if (tick) begin
            state_r  <= adc_ctl_pkg::ST_CONV;
            bitcnt_r <= 4'(`CONV_PERIODS - 1);
          end
        end
        adc_ctl_pkg::ST_CONV: begin
          if (tick) begin
            if (bitcnt_r == 4'h1) state_r <= adc_ctl_pkg::ST_DONE;
            bitcnt_r <= bitcnt_r - 4'h1;
          end
        end
        adc_ctl_pkg::ST_DONE: begin
          state_r    <= adc_ctl_pkg::ST_IDLE;
          prec_run_r <= 1'b0;
        end
        default: state_r <= adc_ctl_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      result_r <= '0;
    end else if (eoc_set) begin
      // Standard mode drops the two low bits
      result_r <= prec_run_r ? conv_result_i
                             : {conv_result_i[RES_W-1:2], 2'b00};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      start_r <= 1'b0;
    end else if (start_req) begin
      start_r <= 1'b1;
    end else if (eoc_set) begin
      start_r <= 1'b0;
    end
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      eoc_r <= 1'b0;
    end else if (eoc_set) begin
      eoc_r <= 1'b1;
    end else if (ctl_wr && !wdata_r[`CTL_EOC_BIT]) begin
      eoc_r <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Analog core and processor controls
  // --------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mux_sel_o <= 3'h0;
    end else if (start_req) begin
      mux_sel_o <= chan_of(wdata_r);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sample_o <= 1'b0;
    end else begin
      sample_o <= (state_r == adc_ctl_pkg::ST_SAMPLE);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      conv_en_o <= 1'b0;
    end else begin
      conv_en_o <= en_r;
    end
  end

  assign core_halt_o = prec_run_r && busy && !eoc_set;
  assign defer_irq_o = core_halt_o;
  assign eoc_irq_o   = eoc_r && ien_r;

  // --------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= addr_ok(s_axi_araddr) ? RESP_OK : RESP_ERR;
      case (s_axi_araddr)
        `OFS_CONTROL:  s_axi_rdata <= {24'h000000, ien_r, prec_r, en_r, eoc_r,
                                       start_r, sel_r};
        `OFS_CHAN_CFG: s_axi_rdata <= {24'h000000, chcfg_r};
        `OFS_PRESCALE: s_axi_rdata <= {27'h0, prs_r};
        `OFS_RESULT:   s_axi_rdata <= {22'h0, result_r};
        default:       s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : adc_conversion_control

// file: verif/adc_ctl_asserts.sv
// Purpose: Port checks for adc_conversion_control
// Assumes: Bound to the top module, one clock domain
// Notes:   Sees a subset of the top ports only
`timescale 1ns/1ns
module adc_ctl_asserts #(
  parameter int NCH = 8
) (
  input wire logic           clk_i,
  input wire logic           rst_n_i,
  input wire logic           s_axi_bvalid,
  input wire logic           s_axi_bready,
  input wire logic [1:0]     s_axi_bresp,
  input wire logic [2:0]     mux_sel_o,
  input wire logic           sample_o,
  input wire logic [NCH-1:0] pin_analog_o,
  input wire logic           core_halt_o,
  input wire logic           defer_irq_o,
  input wire logic           eoc_irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_defer_halt: assert property (defer_irq_o == core_halt_o)
    else $error("deferral differs from halt");
  chk_defer_release: assert property ($fell(defer_irq_o) |=> eoc_irq_o)
    else $error("deferral ended without completion");
  chk_mux_held: assert property (core_halt_o && $past(core_halt_o, 2) |->
    $stable(mux_sel_o)) else $error("channel moved during conversion");
  chk_pin_enabled: assert property ($rose(sample_o) |-> pin_analog_o[mux_sel_o])
    else $error("sampling a disabled channel");
  chk_halt_span: assert property ($rose(core_halt_o) |->
    core_halt_o[*8] ##[1:800] !core_halt_o) else $error("halt length wrong");
  chk_halt_sample: assert property ($rose(core_halt_o) |-> ##[0:3] sample_o)
    else $error("halt without sampling");
  chk_irq_wakes: assert property ($rose(eoc_irq_o) |-> !core_halt_o)
    else $error("interrupt while still halted");
  chk_sample_tick: assert property ($rose(sample_o) |-> ##[1:66] !sample_o)
    else $error("sample phase too long");
  chk_pins_write: assert property ($changed(pin_analog_o) |-> ##[0:2] s_axi_bvalid)
    else $error("pin use changed without write");

  cov_precision: cover property ($rose(core_halt_o));
  cov_irq: cover property ($rose(eoc_irq_o));
  cov_standard: cover property ($rose(sample_o) && !core_halt_o);
endmodule : adc_ctl_asserts

// file: verif/analog_src_model.sv
// Purpose: Analog inputs behind the channel multiplexer
// Assumes: Each channel level is fixed by a seed
// Notes:   Output toggles while the converter is disabled
`timescale 1ns/1ns
module analog_src_model (
  // Clock
  input  wire logic       clk_i,
  // Converter side
  input  wire logic [2:0] mux_sel_i,
  input  wire logic       sample_i,
  input  wire logic       conv_en_i,
  input  wire logic [9:0] seed_i,
  output logic      [9:0] level_o
);
  logic [9:0] hold_r = 10'h000;

  always @(posedge clk_i) begin
    if (sample_i) begin
      hold_r <= seed_i ^ {mux_sel_i, mux_sel_i, mux_sel_i, 1'b1};
    end else if (!conv_en_i) begin
      hold_r <= ~hold_r;
    end
  end
  assign level_o = hold_r;
endmodule : analog_src_model

// file: verif/testbench.sv
// Purpose: Self-checking bench for adc_conversion_control
// Assumes: AXI4-Lite master tasks, analog source model
// Notes:   Small prescale keeps conversions short
`timescale 1ns/1ns
`include "adc_ctl_cfg.svh"
module testbench;
  logic        clk_i, rst_n_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, sample_o, conv_en_o, core_halt_o, defer_irq_o, eoc_irq_o;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [2:0]  mux_sel_o;
  logic [9:0]  conv_result_i, lvl;
  logic [7:0]  pin_analog_o, cfg;
  int          err_count, cmp_count, k, prs, exp_q[$];

  adc_conversion_control u_adc_conversion_control (
    .clk_i (clk_i), .rst_n_i (rst_n_i),
    .s_axi_awvalid (s_axi_awvalid), .s_axi_awready (s_axi_awready),
    .s_axi_awaddr (s_axi_awaddr), .s_axi_wvalid (s_axi_wvalid), .s_axi_wready (s_axi_wready),
    .s_axi_wdata (s_axi_wdata), .s_axi_wstrb (s_axi_wstrb), .s_axi_bvalid (s_axi_bvalid),
    .s_axi_bready (s_axi_bready), .s_axi_bresp (s_axi_bresp),
    .s_axi_arvalid (s_axi_arvalid), .s_axi_arready (s_axi_arready),
    .s_axi_araddr (s_axi_araddr), .s_axi_rvalid (s_axi_rvalid), .s_axi_rready (s_axi_rready),
    .s_axi_rdata (s_axi_rdata), .s_axi_rresp (s_axi_rresp),
    .mux_sel_o (mux_sel_o), .sample_o (sample_o), .conv_en_o (conv_en_o),
    .conv_result_i (conv_result_i), .pin_analog_o (pin_analog_o),
    .core_halt_o (core_halt_o), .defer_irq_o (defer_irq_o), .eoc_irq_o (eoc_irq_o));
  analog_src_model u_analog_src_model (.clk_i, .mux_sel_i(mux_sel_o), .sample_i(sample_o),
    .conv_en_i(conv_en_o), .seed_i(lvl), .level_o(conv_result_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  // ------------------------------------------------
  // Bus cycles
  // ------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] e);
    logic ta, tw, tb;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk_i);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      e = s_axi_bresp;
      @(posedge clk_i);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] e);
    logic ta, tr;
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge clk_i);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      v = s_axi_rdata;
      e = s_axi_rresp;
      @(posedge clk_i);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end
  endtask : rd

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic setcfg(input logic [7:0] c);
    cfg = c;
    wr(`OFS_CHAN_CFG, {24'h0, c}, r);
    @(negedge clk_i);
    chk("pins", pin_analog_o, c);
  endtask : setcfg

  task automatic conv(input int ch, input int pr, input int ie, input int rs);
    int go;
    int n;
    int t0;
    int dt;
    go = cfg[ch];
    wr(`OFS_CONTROL, 32'h28 | ch | pr << 6 | ie << 7, r);
    t0 = int'($time / 10);
    if (rs) wr(`OFS_CONTROL, 32'h28 | (ch ^ 1) | pr << 6 | ie << 7, r);
    @(negedge clk_i);
    chk("halt", core_halt_o, go & pr);
    chk("defer", defer_irq_o, go & pr);
    chk("conv_en", conv_en_o, 1);
    if (go) chk("mux", mux_sel_o, ch);
    if (go) exp_q.push_back((lvl ^ (146 * ch + 1)) & (pr ? 'h3FF : 'h3FC));
    d = 32'h8;
    n = 0;
    while (d[3] && n < 400) begin
      rd(`OFS_CONTROL, d, r);
      n++;
    end
    dt = int'($time / 10) - t0;
    @(negedge clk_i);
    chk("busy", d[3], 0);
    chk("eoc", d[4], go);
    chk("irq", eoc_irq_o, go & ie);
    chk("halt_end", core_halt_o, 0);
    chk("sel", d[2:0], rs ? ch ^ 1 : ch);
    chk("prec_sel", d[6], pr);
    chk("irq_en", d[7], ie);
    if (go) chk("conv_len", 32'(dt >= 22 * prs + 3 && dt <= 22 * prs + 8), 1);
    if (go) begin
      rd(`OFS_RESULT, d, r);
      chk("result", d, exp_q.pop_front());
    end
    wr(`OFS_CONTROL, 32'h20, r);
    @(negedge clk_i);
    chk("irq_clear", eoc_irq_o, 0);
  endtask : conv

  initial begin
    rst_n_i = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 12'h000;
    s_axi_wdata = 32'h0;
    err_count = 0;
    cmp_count = 0;
    void'($urandom(32'h622B8324));
    lvl = 10'($urandom);
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(4'(4 * i), d, r);
      chk("reset", d, 0);
    end
    wr(4'h2, 32'h1, r);
    chk("bresp_bad", r, 2);
    rd(4'h6, d, r);
    chk("rresp_bad", r, 2);
    chk("rdata_bad", d, 0);
    wr(`OFS_RESULT, 32'h3FF, r);
    rd(`OFS_RESULT, d, r);
    chk("result_ro", d, 0);
    prs = 1 + $urandom % 3;
    wr(`OFS_PRESCALE, 32'(prs), r);
    setcfg(8'hFF);
    for (int ch = 0; ch < 8; ch++) begin
      conv(ch, 0, ch % 2, 0);
      conv(ch, 1, 1, ch == 3);
    end
    k = $urandom % 8;
    setcfg(8'($urandom) & ~(8'h01 << k));
    conv(k, 1, 1, 0);
    conv((k + 1) % 8, 0, 1, 0);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    conclude();
  end
endmodule : testbench

bind adc_conversion_control adc_ctl_asserts #(.NCH(NCH)) u_adc_ctl_asserts (
  .clk_i (clk_i), .rst_n_i (rst_n_i), .s_axi_bvalid (s_axi_bvalid),
  .s_axi_bready (s_axi_bready), .s_axi_bresp (s_axi_bresp), .mux_sel_o (mux_sel_o),
  .sample_o (sample_o), .pin_analog_o (pin_analog_o), .core_halt_o (core_halt_o),
  .defer_irq_o (defer_irq_o), .eoc_irq_o (eoc_irq_o));
